//--- common/sfvc_pkg.sv
/*
 * sfvc_pkg: constants for the volatile read configuration register of a
 * serial flash: field positions, reset values, wrap encodings, timing.
 * Assumes: included before every design file that uses it.
 */
package sfvc_pkg;
    localparam int          DUMMY_MSB        = 7;
    localparam int          DUMMY_LSB        = 4;
    localparam int          XIP_BIT          = 3;
    localparam int          RSVD_BIT         = 2;
    localparam int          WRAP_MSB         = 1;
    localparam int          WRAP_LSB         = 0;
    localparam int          NV_DUMMY_MSB     = 15;
    localparam int          NV_DUMMY_LSB     = 12;
    localparam logic [3:0]  DUMMY_ZERO_CODE  = 4'h0;
    localparam logic [3:0]  DUMMY_DEFAULT    = 4'hf;
    localparam logic        XIP_RESET        = 1'b1;
    localparam logic [1:0]  WRAP_RESET       = 2'h3;
    localparam logic [7:0]  WRITE_CONFIG_OPCODE = 8'h81;
    localparam logic [7:0]  READ_CONFIG_OPCODE  = 8'h85;
    localparam int          SYS_CLK_MHZ      = 25;

    typedef enum logic [1:0] {
        SFVC_WRAP_16 = 2'h0,
        SFVC_WRAP_32 = 2'h1,
        SFVC_WRAP_64 = 2'h2,
        SFVC_WRAP_NONE = 2'h3
    } sfvc_wrap_t;
endpackage

//--- rtl/sfvc_config.sv
/*
 * sfvc_config: volatile read configuration register. Holds dummy count,
 * execute-in-place arming and wrap size; loads the dummy count from the
 * non-volatile image at reset; written by the write instruction over SPI.
 * Assumes: i_nv_config is stable while i_sys_rst is high.
 */
`timescale 1ns/10ps
module sfvc_config #(
    parameter bit BASIC_XIP = 1'b0
) (
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    input  wire logic        i_link_clock,
    input  wire logic        i_cs_n,
    input  wire logic        i_data_line_zero,
    output logic             o_data_line_one,
    output logic             o_data_line_one_oe,
    input  wire logic [15:0] i_nv_config,
    input  wire logic        i_dummy_first_bit,
    input  wire logic [23:0] i_read_addr,
    input  wire logic        i_read_next,
    output logic [3:0]       o_dummy_cycles,
    output logic             o_xip_armed,
    output logic             o_xip_confirm,
    output logic [23:0]      o_next_addr,
    output logic [7:0]       o_volatile_read_configuration
);
    logic [3:0] dummy_code;
    logic       xip_bit;
    logic [1:0] wrap_code;
    logic [7:0] link_byte;
    logic       link_toggle;
    logic       tog_meta;
    logic       tog_sync;
    logic       tog_seen;
    logic       wr_pulse;
    logic [23:0] next_addr;
    logic [23:0] wrap_mask;
    logic [23:0] addr_inc;

    // read value is quasi-static: it moves only a few clocks after a write
    // frame ends, and frames are spaced wider than that
    sfvc_link u_link (
        .i_link_clock       (i_link_clock),
        .i_sys_rst          (i_sys_rst),
        .i_cs_n             (i_cs_n),
        .i_data_line_zero   (i_data_line_zero),
        .i_rd_value         (o_volatile_read_configuration),
        .o_data_line_one    (o_data_line_one),
        .o_data_line_one_oe (o_data_line_one_oe),
        .o_wr_byte          (link_byte),
        .o_wr_toggle        (link_toggle)
    );

    // toggle crossing; meta stage feeds only the second flop
    always_ff @(posedge i_clock) begin
        tog_meta <= link_toggle;
        tog_sync <= tog_meta;
    end

    // seen copy follows the synced toggle through reset, so no false edge after it
    always_ff @(posedge i_clock) begin
        tog_seen <= tog_sync;
    end

    // a write that completes while reset is high is lost
    assign wr_pulse = !i_sys_rst && (tog_sync != tog_seen);

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            dummy_code <= i_nv_config[sfvc_pkg::NV_DUMMY_MSB:sfvc_pkg::NV_DUMMY_LSB];
        end else if (wr_pulse) begin
            // byte stable since toggle was two flops behind it
            dummy_code <= link_byte[sfvc_pkg::DUMMY_MSB:sfvc_pkg::DUMMY_LSB];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            xip_bit <= sfvc_pkg::XIP_RESET;
        end else if (wr_pulse) begin
            xip_bit <= link_byte[sfvc_pkg::XIP_BIT];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wrap_code <= sfvc_pkg::WRAP_RESET;
        end else if (wr_pulse) begin
            wrap_code <= link_byte[sfvc_pkg::WRAP_MSB:sfvc_pkg::WRAP_LSB];
        end
    end

    always_comb begin
        o_volatile_read_configuration = {dummy_code, xip_bit, 1'b0, wrap_code};
    end

    // zero code aliases to fifteen; default 1111 gives 15
    assign o_dummy_cycles = (dummy_code == sfvc_pkg::DUMMY_ZERO_CODE)
                            ? sfvc_pkg::DUMMY_DEFAULT : dummy_code;

    assign o_xip_armed   = BASIC_XIP | !xip_bit;
    assign o_xip_confirm = o_xip_armed & !i_dummy_first_bit;

    always_comb begin
        unique case (sfvc_pkg::sfvc_wrap_t'(wrap_code))
            sfvc_pkg::SFVC_WRAP_16: wrap_mask = 24'h00000f;
            sfvc_pkg::SFVC_WRAP_32: wrap_mask = 24'h00001f;
            sfvc_pkg::SFVC_WRAP_64: wrap_mask = 24'h00003f;
            sfvc_pkg::SFVC_WRAP_NONE: wrap_mask = 24'hffffff;
        endcase
    end

    // same step for every read kind and protocol; bits above the block hold
    assign addr_inc = i_read_addr + 24'h000001;
    for (genvar b = 0; b < 24; b++) begin : g_addr_bit
        assign next_addr[b] = wrap_mask[b] ? addr_inc[b] : i_read_addr[b];
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_next_addr <= 24'h000000;
        end else if (i_read_next) begin
            o_next_addr <= next_addr;
        end
    end
endmodule // sfvc_config

//--- rtl/sfvc_link.sv
/*
 * sfvc_link: serial-clock side of the configuration register. Shifts in
 * an opcode and a data byte with the frame, and at the 16th bit of a write
 * frame flips a toggle that hands the byte to the system clock domain.
 * Assumes: mode-0 sampling on rising serial clock, chip select low active;
 * system reset clears the hand-over toggle while the serial clock is still.
 */
`timescale 1ns/10ps
module sfvc_link (
    input  wire logic       i_link_clock,
    input  wire logic       i_sys_rst,
    input  wire logic       i_cs_n,
    input  wire logic       i_data_line_zero,
    input  wire logic [7:0] i_rd_value,
    output logic            o_data_line_one,
    output logic            o_data_line_one_oe,
    output logic [7:0]      o_wr_byte,
    output logic            o_wr_toggle
);
    logic [4:0] bit_cnt;
    logic [7:0] opcode;
    logic [7:0] shift;
    logic [7:0] rd_shift;
    logic       wr_last;

    // counter restarts with each frame; clock may stop between frames
    // it runs past bit 16 so trailing bits cannot write a second time
    always_ff @(posedge i_link_clock or posedge i_cs_n) begin
        if (i_cs_n) begin
            bit_cnt <= 5'h00;
        end else if (bit_cnt != 5'h1f) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    always_ff @(posedge i_link_clock) begin
        if (!i_cs_n) begin
            shift <= {shift[6:0], i_data_line_zero};
            if (bit_cnt == 5'h07) begin
                opcode <= {shift[6:0], i_data_line_zero};
            end
        end
    end

    assign wr_last = !i_cs_n && (bit_cnt == 5'h0f)
                     && (opcode == sfvc_pkg::WRITE_CONFIG_OPCODE);

    // byte and toggle settle together; receiver reads byte after toggle sync
    always_ff @(posedge i_link_clock) begin
        if (wr_last) begin
            o_wr_byte <= {shift[6:0], i_data_line_zero};
        end
    end

    // toggle must start known, and the serial clock may be still during reset
    always_ff @(posedge i_link_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wr_toggle <= 1'b0;
        end else if (wr_last) begin
            o_wr_toggle <= !o_wr_toggle;
        end
    end

    // read path: value shifts out on falling edge after the opcode
    always_ff @(negedge i_link_clock or posedge i_cs_n) begin
        if (i_cs_n) begin
            rd_shift           <= 8'h00;
            o_data_line_one_oe <= 1'b0;
        end else if (bit_cnt == 5'h08 && opcode == sfvc_pkg::READ_CONFIG_OPCODE) begin
            rd_shift           <= i_rd_value;
            o_data_line_one_oe <= 1'b1;
        end else begin
            rd_shift <= {rd_shift[6:0], 1'b0};
        end
    end

    assign o_data_line_one = rd_shift[7];
endmodule // sfvc_link

//--- verification/sfvc_config_monitor.sv
/* sfvc_config_monitor: port checks of sfvc_config.
   Assumes binding to sfvc_config; all checks on i_clock. */
`timescale 1ns/10ps
module sfvc_config_monitor #(
    parameter bit BASIC_XIP = 1'b0
) (
    input wire logic        i_clock,
    input wire logic        i_sys_rst,
    input wire logic        i_cs_n,
    input wire logic [15:0] i_nv_config,
    input wire logic        i_dummy_first_bit,
    input wire logic [23:0] i_read_addr,
    input wire logic        i_read_next,
    input wire logic [3:0]  o_dummy_cycles,
    input wire logic        o_xip_armed,
    input wire logic        o_xip_confirm,
    input wire logic [23:0] o_next_addr,
    input wire logic [7:0]  o_volatile_read_configuration
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    wire  [7:0]  vrc = o_volatile_read_configuration;
    logic [23:0] msk;
    logic [23:0] nxt;
    always_comb msk = (vrc[1:0] == 2'h3) ? 24'hffffff : (24'h10 << vrc[1:0]) - 24'h1;
    always_comb nxt = (i_read_addr & ~msk) | ((i_read_addr + 24'h1) & msk);
    a_dummy_zero: assert property (vrc[7:4] == 4'h0 |-> o_dummy_cycles == 4'hf)
        else $error("zero dummy code not 15");
    a_dummy_direct: assert property (vrc[7:4] != 4'h0 |-> o_dummy_cycles == vrc[7:4])
        else $error("dummy count wrong");
    a_rsvd_zero: assert property (vrc[2] == 1'b0)
        else $error("reserved bit set");
    a_xip_level: assert property (o_xip_armed == (BASIC_XIP || !vrc[3]))
        else $error("xip arming wrong");
    a_xip_confirm: assert property (o_xip_confirm == (o_xip_armed && !i_dummy_first_bit))
        else $error("xip confirm wrong");
    a_reset_load: assert property ($fell(i_sys_rst) |-> vrc == {i_nv_config[15:12], 4'hb})
        else $error("reset value wrong");
    a_addr_step: assert property (i_read_next |=> o_next_addr == $past(nxt))
        else $error("address step wrong");
    a_reg_stable: assert property (i_cs_n [*6] |=> $stable(vrc))
        else $error("register changed without write");
endmodule // sfvc_config_monitor
bind sfvc_config sfvc_config_monitor #(.BASIC_XIP(BASIC_XIP)) u_sfvc_config_monitor (.*);

//--- verification/sfvc_host_model.sv
/* sfvc_host_model: behavioural spi host for sfvc_config.
   Assumes mode 0 and a serial clock that runs only inside frames. */
`timescale 1ns/10ps
module sfvc_host_model (
    output logic      o_link_clock,
    output logic      o_cs_n,
    output logic      o_data_line_zero,
    input  wire logic i_data_line_one,
    input  wire logic i_data_line_one_oe
);
    initial begin
        o_link_clock     = 1'b0;
        o_cs_n           = 1'b1;
        o_data_line_zero = 1'b0;
    end
    // bit 2 is sent as zero by the caller in every write frame (opcode 8'h81)
    task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] r);
        for (int i = 15; i > 15 - n; i--) begin
            o_cs_n = 1'b0;
            o_data_line_zero = w[i];
            #24 o_link_clock = 1'b1;
            // undriven line reads back inverted, so a missing enable shows
            if (i < 8) r[i] = i_data_line_one_oe ? i_data_line_one : ~i_data_line_one;
            #24 o_link_clock = 1'b0;
        end
        #24 o_cs_n = 1'b1;
        // released line must not look like a held bit
        o_data_line_zero = ~o_data_line_zero;
        #240;
    endtask
endmodule // sfvc_host_model

//--- verification/tb_sfvc_config.sv
/* tb_sfvc_config: self-checking bench for sfvc_config.
   Assumes sfvc_host_model as spi host and the bound monitor. */
`timescale 1ns/10ps
module tb_sfvc_config;
    logic        i_clock, i_sys_rst, i_dummy_first_bit, i_read_next;
    logic [15:0] i_nv_config;
    logic [23:0] i_read_addr;
    wire         lclk, cs_n, dlz, dlo, dlo_oe, xip_basic, o_xip_armed, o_xip_confirm;
    wire  [3:0]  o_dummy_cycles;
    wire  [23:0] o_next_addr;
    wire  [7:0]  o_vrc;
    int          n_fail = 0, checked = 0, seed = 66, m, a, sz;
    logic [7:0]  r, v;
    logic [7:0]  vals[$] = '{8'h00, 8'h51, 8'h12, 8'hf8, 8'he3};
    sfvc_config u_sfvc_config (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_link_clock(lclk),
        .i_cs_n(cs_n), .i_data_line_zero(dlz), .o_data_line_one(dlo),
        .o_data_line_one_oe(dlo_oe),
        .i_nv_config(i_nv_config), .i_dummy_first_bit(i_dummy_first_bit),
        .i_read_addr(i_read_addr), .i_read_next(i_read_next), .o_dummy_cycles(o_dummy_cycles),
        .o_xip_armed(o_xip_armed), .o_xip_confirm(o_xip_confirm), .o_next_addr(o_next_addr),
        .o_volatile_read_configuration(o_vrc));
    // basic variant: arming bit ignored
    sfvc_config #(.BASIC_XIP(1'b1)) u_sfvc_config_basic (.i_clock(i_clock),
        .i_sys_rst(i_sys_rst), .i_link_clock(lclk), .i_cs_n(cs_n), .i_data_line_zero(dlz),
        .o_data_line_one(), .o_data_line_one_oe(), .i_nv_config(i_nv_config),
        .i_dummy_first_bit(i_dummy_first_bit), .i_read_addr(i_read_addr),
        .i_read_next(i_read_next), .o_dummy_cycles(), .o_xip_armed(xip_basic),
        .o_xip_confirm(), .o_next_addr(), .o_volatile_read_configuration());
    sfvc_host_model u_sfvc_host_model (.o_link_clock(lclk), .o_cs_n(cs_n),
        .o_data_line_zero(dlz), .i_data_line_one(dlo), .i_data_line_one_oe(dlo_oe));
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    initial begin
        #1000000;
        n_fail++;
        test_done;
    end
    task chk(input logic [23:0] g, input logic [23:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task test_done;
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    initial begin
        {i_dummy_first_bit, i_read_next, i_read_addr} = '0;
        i_nv_config = 16'hffff;
        i_sys_rst = 1'b0;
        #1;
        for (int k = 0; k < 2; k++) begin
            i_sys_rst = 1'b1;
            tick(5);
            i_sys_rst = 1'b0;
            tick(1);
            chk(24'(o_vrc), 24'({i_nv_config[15:12], 4'hb}));
            m = (i_nv_config[15:12] == 4'h0) ? 15 : i_nv_config[15:12];
            chk(24'(o_dummy_cycles), 24'(m));
            chk(o_next_addr, 24'h000000);
            i_nv_config = 16'($random(seed));
        end
        repeat (6) vals.push_back(8'($random(seed)) & 8'hfb);
        foreach (vals[j]) begin
            v = vals[j];
            u_sfvc_host_model.xfer({8'h81, v}, 16, r);
            tick(6);
            chk(24'(o_vrc), 24'(v));
            chk(24'(o_dummy_cycles), 24'(v[7:4] == 4'h0 ? 15 : v[7:4]));
            i_dummy_first_bit = 1'($random(seed));
            tick(1);
            chk(24'({o_xip_armed, o_xip_confirm}), 24'({~v[3], ~v[3] & ~i_dummy_first_bit}));
            chk(24'(xip_basic), 24'h000001);
            u_sfvc_host_model.xfer({8'h85, 8'h00}, 16, r);
            chk(24'(r), 24'(v));
            chk(24'(dlo_oe), 24'h000000);
            a = $random(seed) & 24'hffffff;
            i_read_addr = 24'(a);
            i_read_next = 1'b1;
            tick(1);
            i_read_next = 1'b0;
            sz = 16 << v[1:0];
            if (v[1:0] == 2'h3) m = a + 1;
            else m = a - a % sz + (a + 1) % sz;
            chk(o_next_addr, 24'(m));
        end
        u_sfvc_host_model.xfer({8'h42, 8'h0f}, 16, r);
        u_sfvc_host_model.xfer({8'h81, 8'h0f}, 12, r);
        tick(6);
        chk(24'(o_vrc), 24'(v));
        test_done;
    end
endmodule // tb_sfvc_config
